// ===== hw/pwr_out_ctrl_defs.svh
// register offsets, field positions, reset values and the output phase limit of the power/output control bank
// What this block does
// - all registers except override apply when written
// - commit bit zero applies pending override settings
// - pin function bit: pin gives standby or power-down
// - mode zero keeps all channels active
// - mode one gates clocks, resets path, disables outputs
// - mode two gates clocks and disables outputs
// - mode three resets data path and disables outputs, clocks not gated
// - control port reset only by power-on reset
// - chop enable bit turns on first-stage chopping
// - standard bit selects ANSI or IEEE levels
// - invert bit inverts every output stream bit
// - format bit defaults one, twos complement
// - two-bit field selects output termination
// - drive bit doubles drive on frame and data clocks selected in index b
// - termination wins over double clock drive
// - input phase delays sampling zero to seven cycles
// - device index selects channels for local writes
`ifndef PWR_OUT_CTRL_DEFS_SVH
`define PWR_OUT_CTRL_DEFS_SVH
`define ADDR_DEVICE_INDEX_A   13'h0004
`define ADDR_DEVICE_INDEX_B   13'h0005
`define ADDR_POWER_MODE       13'h0008
`define ADDR_ENHANCEMENT      13'h000C
`define ADDR_OUTPUT_MODE      13'h0014
`define ADDR_OUTPUT_ADJUST    13'h0015
`define ADDR_CLOCK_PHASE      13'h0016
`define ADDR_COMMIT           13'h00FF
`define ADDR_OVERRIDE         13'h0100
`define BIT_PIN_FUNCTION      5
`define BIT_CHOP              2
`define BIT_STANDARD          6
`define BIT_INVERT            2
`define BIT_FORMAT            0
`define BIT_DRIVE             0
`define BIT_COMMIT            0
`define BIT_CLOCK_SELECT_FCO  4
`define BIT_CLOCK_SELECT_DCO  5
`define RESET_POWER_MODE      8'h00
`define RESET_ENHANCEMENT     8'h00
`define RESET_OUTPUT_MODE     8'h01
`define RESET_OUTPUT_ADJUST   8'h00
`define RESET_CLOCK_PHASE     8'h03
`define RESET_OVERRIDE        8'h00
`define RESET_INDEX           8'h0F
`define MAX_OUTPUT_PHASE      4'hB
`endif

// ===== hw/pwr_out_ctrl_pkg.sv
// types shared by the power/output control bank
package pwr_out_ctrl_pkg;
  typedef enum logic [1:0] {
    mode_normal     = 2'h0,
    mode_power_down = 2'h1,
    mode_standby    = 2'h2,
    mode_reset      = 2'h3
  } power_mode_type;
  typedef logic [7:0]  reg_byte_type;
  typedef logic [12:0] reg_addr_type;
endpackage

// ===== hw/pin_sync.sv
// two-flop synchroniser for an asynchronous pin
`timescale 1ns/1ps
module pin_sync (
  input  wire logic clock,
  input  wire logic reset_n,
  input  wire logic pin_in,
  output logic      pin_out
);
  logic stage_one;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      stage_one <= 1'b0;
      pin_out   <= 1'b0;
    end else begin
      stage_one <= pin_in;
      pin_out   <= stage_one;
    end
  end
endmodule // pin_sync

// ===== hw/channel_reg.sv
// per-channel register byte with write gated by channel selection
`timescale 1ns/1ps
module channel_reg #(
  parameter logic [7:0] RESET_VALUE = 8'h00
) (
  input  wire logic       clock,
  input  wire logic       reset_n,
  input  wire logic       write_enable,
  input  wire logic [7:0] write_data,
  output logic [7:0]      value
);
  logic [7:0] next_value;
  always_comb begin
    next_value = write_enable ? write_data : value;
  end
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      value <= RESET_VALUE;
    end else begin
      value <= next_value;
    end
  end
endmodule // channel_reg

// ===== hw/adc_power_output_control_regs.sv
// control register bank for power modes and output behaviour of an octal converter
`timescale 1ns/1ps
`include "pwr_out_ctrl_defs.svh"
module adc_power_output_control_regs #(
  parameter int CHANNELS = 8
) (
  input  wire logic                          clock,
  input  wire logic                          reset_n,
  input  wire logic                          write_strobe,
  input  wire logic                          read_strobe,
  input  wire pwr_out_ctrl_pkg::reg_addr_type address,
  input  wire pwr_out_ctrl_pkg::reg_byte_type write_data,
  input  wire logic                          power_down_pin,
  output pwr_out_ctrl_pkg::reg_byte_type     read_data,
  output logic                               read_valid,
  output logic [CHANNELS-1:0]                channel_active,
  output logic [CHANNELS-1:0]                path_clock_gate,
  output logic [CHANNELS-1:0]                path_reset,
  output logic [CHANNELS-1:0]                output_enable,
  output logic [CHANNELS-1:0]                chop_enable,
  output logic [CHANNELS-1:0]                ieee_standard,
  output logic [CHANNELS-1:0]                invert_stream,
  output logic [CHANNELS-1:0]                twos_complement,
  output logic [1:0]                         termination,
  output logic                               frame_clock_output_double,
  output logic                               data_clock_output_double,
  output logic [2:0]                         input_phase_delay,
  output logic [3:0]                         output_phase_code,
  output pwr_out_ctrl_pkg::reg_byte_type     override_applied
);
  import pwr_out_ctrl_pkg::*;

  // ----------------------------------------------------------------
  // reset release and pin synchronisation
  // ----------------------------------------------------------------
  logic reset_meta;
  logic reset_sync_n;
  always_ff @(posedge clock or negedge reset_n) begin
    if (!reset_n) begin
      reset_meta   <= 1'b0;
      reset_sync_n <= 1'b0;
    end else begin
      reset_meta   <= 1'b1;
      reset_sync_n <= reset_meta;
    end
  end

  logic pin_level;
  pin_sync u_pin_sync (
    .clock   (clock),
    .reset_n (reset_sync_n),
    .pin_in  (power_down_pin),
    .pin_out (pin_level)
  );

  // ----------------------------------------------------------------
  // channel selection and global registers
  // ----------------------------------------------------------------
  logic [7:0] index_a;
  logic [7:0] index_b;
  logic [7:0] power_mode_control;
  logic [7:0] output_adjust_control;
  logic [7:0] clock_phase_control;
  logic [7:0] override_pending;
  logic [7:0] next_index_a;
  logic [7:0] next_index_b;
  logic [7:0] next_power_mode;
  logic [7:0] next_output_adjust;
  logic [7:0] next_clock_phase;
  logic [7:0] next_override_pending;
  logic [7:0] next_override_applied;

  function automatic logic hit(input reg_addr_type a, input reg_addr_type target);
    return a == target;
  endfunction

  // channels 0..3 selected by index b, 4..7 by index a
  logic [CHANNELS-1:0] channel_select;
  always_comb begin
    channel_select = '0;
    for (int i = 0; i < CHANNELS; i++) begin
      channel_select[i] = (i < 4) ? index_b[i % 4] : index_a[i % 4];
    end
  end

  always_comb begin
    next_index_a          = index_a;
    next_index_b          = index_b;
    next_power_mode       = power_mode_control;
    next_output_adjust    = output_adjust_control;
    next_clock_phase      = clock_phase_control;
    next_override_pending = override_pending;
    next_override_applied = override_applied;
    if (write_strobe) begin
      if (hit(address, `ADDR_DEVICE_INDEX_A)) next_index_a = write_data;
      if (hit(address, `ADDR_DEVICE_INDEX_B)) next_index_b = write_data;
      if (hit(address, `ADDR_POWER_MODE)) next_power_mode = write_data & 8'h23;
      if (hit(address, `ADDR_OUTPUT_ADJUST)) next_output_adjust = write_data & 8'h31;
      if (hit(address, `ADDR_CLOCK_PHASE)) begin
        next_clock_phase[6:4] = write_data[6:4];
        if (write_data[3:0] <= `MAX_OUTPUT_PHASE) begin
          next_clock_phase[3:0] = write_data[3:0];
        end
      end
      if (hit(address, `ADDR_OVERRIDE)) next_override_pending = write_data;
      if (hit(address, `ADDR_COMMIT) && write_data[`BIT_COMMIT]) begin
        next_override_applied = override_pending;
      end
    end
  end

  // the control port registers live on the power-on reset only, no mode resets them
  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      index_a               <= `RESET_INDEX;
      index_b               <= `RESET_INDEX;
      power_mode_control    <= `RESET_POWER_MODE;
      output_adjust_control <= `RESET_OUTPUT_ADJUST;
      clock_phase_control   <= `RESET_CLOCK_PHASE;
      override_pending      <= `RESET_OVERRIDE;
      override_applied      <= `RESET_OVERRIDE;
    end else begin
      index_a               <= next_index_a;
      index_b               <= next_index_b;
      power_mode_control    <= next_power_mode;
      output_adjust_control <= next_output_adjust;
      clock_phase_control   <= next_clock_phase;
      override_pending      <= next_override_pending;
      override_applied      <= next_override_applied;
    end
  end

  // ----------------------------------------------------------------
  // per-channel registers
  // ----------------------------------------------------------------
  logic [7:0] enhancement [CHANNELS];
  logic [7:0] output_mode [CHANNELS];
  genvar g;
  generate
    for (g = 0; g < CHANNELS; g++) begin : g_chan
      channel_reg #(.RESET_VALUE(`RESET_ENHANCEMENT)) u_enh (
        .clock        (clock),
        .reset_n      (reset_sync_n),
        .write_enable (write_strobe && channel_select[g] && hit(address, `ADDR_ENHANCEMENT)),
        .write_data   (write_data & 8'h04),
        .value        (enhancement[g])
      );
      channel_reg #(.RESET_VALUE(`RESET_OUTPUT_MODE)) u_mode (
        .clock        (clock),
        .reset_n      (reset_sync_n),
        .write_enable (write_strobe && channel_select[g] && hit(address, `ADDR_OUTPUT_MODE)),
        .write_data   (write_data & 8'h45),
        .value        (output_mode[g])
      );
    end
  endgenerate

  // lowest selected channel answers a read of a local register
  logic [2:0] read_channel;
  always_comb begin
    read_channel = 3'h0;
    for (int i = CHANNELS - 1; i >= 0; i--) begin
      if (channel_select[i]) read_channel = 3'(i);
    end
  end

  // ----------------------------------------------------------------
  // effective power mode and derived controls
  // ----------------------------------------------------------------
  power_mode_type mode;
  always_comb begin
    mode = power_mode_type'(power_mode_control[1:0]);
    if (pin_level) begin
      mode = power_mode_control[`BIT_PIN_FUNCTION] ? mode_standby : mode_power_down;
    end
  end

  logic                next_active;
  logic                next_gate;
  logic                next_reset;
  logic                next_out;
  logic [CHANNELS-1:0] next_chop;
  logic [CHANNELS-1:0] next_ieee;
  logic [CHANNELS-1:0] next_invert;
  logic [CHANNELS-1:0] next_twos;
  logic                next_fco_double;
  logic                next_dco_double;
  logic [7:0]          next_read_data;
  always_comb begin
    next_active = 1'b1;
    next_gate   = 1'b0;
    next_reset  = 1'b0;
    next_out    = 1'b1;
    unique case (mode)
      mode_normal: begin
        next_active = 1'b1;
      end
      mode_power_down: begin
        next_active = 1'b0;
        next_gate   = 1'b1;
        next_reset  = 1'b1;
        next_out    = 1'b0;
      end
      mode_standby: begin
        next_active = 1'b0;
        next_gate   = 1'b1;
        next_out    = 1'b0;
      end
      mode_reset: begin
        next_active = 1'b0;
        next_reset  = 1'b1;
        next_out    = 1'b0;
      end
    endcase
    for (int i = 0; i < CHANNELS; i++) begin
      next_chop[i]   = enhancement[i][`BIT_CHOP];
      next_ieee[i]   = output_mode[i][`BIT_STANDARD];
      next_invert[i] = output_mode[i][`BIT_INVERT];
      next_twos[i]   = output_mode[i][`BIT_FORMAT];
    end
    next_fco_double = output_adjust_control[`BIT_DRIVE] && index_b[`BIT_CLOCK_SELECT_FCO]
                      && output_adjust_control[5:4] == 2'h0;
    next_dco_double = output_adjust_control[`BIT_DRIVE] && index_b[`BIT_CLOCK_SELECT_DCO]
                      && output_adjust_control[5:4] == 2'h0;
    next_read_data = 8'h00;
    if (hit(address, `ADDR_DEVICE_INDEX_A)) next_read_data = index_a;
    if (hit(address, `ADDR_DEVICE_INDEX_B)) next_read_data = index_b;
    if (hit(address, `ADDR_POWER_MODE)) next_read_data = power_mode_control;
    if (hit(address, `ADDR_ENHANCEMENT)) next_read_data = enhancement[read_channel];
    if (hit(address, `ADDR_OUTPUT_MODE)) next_read_data = output_mode[read_channel];
    if (hit(address, `ADDR_OUTPUT_ADJUST)) next_read_data = output_adjust_control;
    if (hit(address, `ADDR_CLOCK_PHASE)) next_read_data = clock_phase_control;
    if (hit(address, `ADDR_OVERRIDE)) next_read_data = override_pending;
  end

  always_ff @(posedge clock or negedge reset_sync_n) begin
    if (!reset_sync_n) begin
      channel_active            <= '1;
      path_clock_gate           <= '0;
      path_reset                <= '0;
      output_enable             <= '1;
      chop_enable               <= '0;
      ieee_standard             <= '0;
      invert_stream             <= '0;
      twos_complement           <= '1;
      termination               <= 2'h0;
      frame_clock_output_double <= 1'b0;
      data_clock_output_double  <= 1'b0;
      input_phase_delay         <= 3'h0;
      output_phase_code         <= 4'h3;
      read_data                 <= 8'h00;
      read_valid                <= 1'b0;
    end else begin
      channel_active            <= {CHANNELS{next_active}};
      path_clock_gate           <= {CHANNELS{next_gate}};
      path_reset                <= {CHANNELS{next_reset}};
      output_enable             <= {CHANNELS{next_out}};
      chop_enable               <= next_chop;
      ieee_standard             <= next_ieee;
      invert_stream             <= next_invert;
      twos_complement           <= next_twos;
      termination               <= output_adjust_control[5:4];
      frame_clock_output_double <= next_fco_double;
      data_clock_output_double  <= next_dco_double;
      input_phase_delay         <= clock_phase_control[6:4];
      output_phase_code         <= clock_phase_control[3:0];
      read_data                 <= next_read_data;
      read_valid                <= read_strobe;
    end
  end

  // ----------------------------------------------------------------
  // assertions
  // ----------------------------------------------------------------
  a_commit_applies: assert property (@(posedge clock) disable iff (!reset_sync_n)
    write_strobe && address == `ADDR_COMMIT && write_data[0] |=> override_applied == $past(override_pending))
    else $error("commit did not apply override");
  a_override_held: assert property (@(posedge clock) disable iff (!reset_sync_n)
    !(write_strobe && address == `ADDR_COMMIT) |=> $stable(override_applied))
    else $error("override changed without commit");
  a_power_down_outputs: assert property (@(posedge clock) disable iff (!reset_sync_n)
    mode == mode_power_down |=> path_reset[0] && path_clock_gate[0] && !output_enable[0])
    else $error("power-down outputs wrong");
  a_standby_outputs: assert property (@(posedge clock) disable iff (!reset_sync_n)
    mode == mode_standby |=> !path_reset[0] && path_clock_gate[0] && !output_enable[0])
    else $error("standby outputs wrong");
  a_reset_mode_outputs: assert property (@(posedge clock) disable iff (!reset_sync_n)
    mode == mode_reset |=> path_reset[0] && !output_enable[0] && !channel_active[0])
    else $error("reset mode outputs wrong");
  a_normal_active: assert property (@(posedge clock) disable iff (!reset_sync_n)
    mode == mode_normal |=> channel_active == '1 && output_enable == '1)
    else $error("normal mode not active");
  a_pin_standby: assert property (@(posedge clock) disable iff (!reset_sync_n)
    pin_level && power_mode_control[5] |=> path_clock_gate[0] && !path_reset[0])
    else $error("pin standby wrong");
  a_term_precedence: assert property (@(posedge clock) disable iff (!reset_sync_n)
    output_adjust_control[5:4] != 2'h0 |=> !data_clock_output_double && !frame_clock_output_double)
    else $error("double drive with termination");
  a_phase_reserved: assert property (@(posedge clock) disable iff (!reset_sync_n)
    write_strobe && address == `ADDR_CLOCK_PHASE && write_data[3:0] > 4'hB |=> $stable(clock_phase_control[3:0]))
    else $error("reserved phase accepted");
  a_phase_range: assert property (@(posedge clock) disable iff (!reset_sync_n)
    output_phase_code <= 4'hB) else $error("output phase out of range");
  c_commit: cover property (@(posedge clock) write_strobe && address == `ADDR_COMMIT && write_data[0]);
  c_standby: cover property (@(posedge clock) mode == mode_standby);
  c_reset_mode: cover property (@(posedge clock) mode == mode_reset);
endmodule // adc_power_output_control_regs

// ===== verif/host_model.sv
// host controller model that writes and reads the control bank registers
`timescale 1ns/1ps
module host_model (
  input  wire logic                          clock,
  input  wire pwr_out_ctrl_pkg::reg_byte_type read_data,
  input  wire logic                          read_valid,
  output logic                               write_strobe,
  output logic                               read_strobe,
  output pwr_out_ctrl_pkg::reg_addr_type     address,
  output pwr_out_ctrl_pkg::reg_byte_type     write_data
);
  import pwr_out_ctrl_pkg::*;
  initial begin
    write_strobe = 1'b0;
    read_strobe  = 1'b0;
    address      = 13'h0000;
    write_data   = 8'h00;
  end
  // one-cycle write; data is inverted once the strobe drops
  task automatic wr(input reg_addr_type a, input reg_byte_type d);
    @(posedge clock);
    #1;
    address      = a;
    write_data   = d;
    write_strobe = 1'b1;
    @(posedge clock);
    #1;
    write_strobe = 1'b0;
    write_data   = ~d;
  endtask
  // one-cycle read; read_valid stands only in the cycle after the request edge, read_data follows the address for as long as it is held
  task automatic rd(input reg_addr_type a, output reg_byte_type d, output logic v);
    @(posedge clock);
    #1;
    address     = a;
    read_strobe = 1'b1;
    @(posedge clock);
    #1;
    d           = read_data;
    v           = read_valid;
    read_strobe = 1'b0;
  endtask
endmodule // host_model

// ===== verif/tb.sv
// self-checking testbench of the power/output control bank
`timescale 1ns/1ps
`include "pwr_out_ctrl_defs.svh"
module tb;
  import pwr_out_ctrl_pkg::*;
  logic           clock;
  logic           reset_n;
  logic           power_down_pin;
  logic           write_strobe;
  logic           read_strobe;
  reg_addr_type   address;
  reg_byte_type   write_data;
  reg_byte_type   read_data;
  logic           read_valid;
  logic [7:0]     channel_active;
  logic [7:0]     path_clock_gate;
  logic [7:0]     path_reset;
  logic [7:0]     output_enable;
  logic [7:0]     chop_enable;
  logic [7:0]     ieee_standard;
  logic [7:0]     invert_stream;
  logic [7:0]     twos_complement;
  logic [1:0]     termination;
  logic           fco_double;
  logic           dco_double;
  logic [2:0]     input_phase_delay;
  logic [3:0]     output_phase_code;
  reg_byte_type   override_applied;
  int             bad_count;
  int             n_compared;
  reg_byte_type   rdata;
  logic           rvalid;
  logic [7:0]     gate_tab [4] = '{8'h00, 8'hFF, 8'hFF, 8'h00};
  logic [7:0]     rst_tab  [4] = '{8'h00, 8'hFF, 8'h00, 8'hFF};
  logic [7:0]     oe_tab   [4] = '{8'hFF, 8'h00, 8'h00, 8'h00};

  adc_power_output_control_regs #(.CHANNELS(8)) i_dut (
    .clock(clock), .reset_n(reset_n), .write_strobe(write_strobe), .read_strobe(read_strobe),
    .address(address), .write_data(write_data), .power_down_pin(power_down_pin),
    .read_data(read_data), .read_valid(read_valid), .channel_active(channel_active),
    .path_clock_gate(path_clock_gate), .path_reset(path_reset), .output_enable(output_enable),
    .chop_enable(chop_enable), .ieee_standard(ieee_standard), .invert_stream(invert_stream),
    .twos_complement(twos_complement), .termination(termination),
    .frame_clock_output_double(fco_double), .data_clock_output_double(dco_double),
    .input_phase_delay(input_phase_delay), .output_phase_code(output_phase_code),
    .override_applied(override_applied));

  host_model i_host (
    .clock(clock), .read_data(read_data), .read_valid(read_valid), .write_strobe(write_strobe),
    .read_strobe(read_strobe), .address(address), .write_data(write_data));

  initial clock = 1'b0;
  always #50 clock = ~clock;

  //----------------------------------------
  // comparison and closing helpers
  //----------------------------------------
  task automatic chk(input logic [7:0] got, input logic [7:0] exp);
    n_compared++;
    if (got !== exp) begin
      bad_count++;
      $display("ERROR at %0t: got %h expected %h", $time, got, exp);
    end
  endtask
  task automatic rchk(input reg_addr_type a, input reg_byte_type exp);
    i_host.rd(a, rdata, rvalid);
    chk({7'h00, rvalid}, 8'h01);
    chk(rdata, exp);
  endtask
  task automatic settle(input int n);
    repeat (n) @(posedge clock);
    #1;
  endtask
  task automatic final_report;
    $display("compared %0d, mismatches %0d", n_compared, bad_count);
    if (bad_count == 0 && n_compared > 0) begin
      $display("ALL TESTS PASSED");
    end else begin
      $display("TESTS FAILED");
    end
    $finish;
  endtask

  initial begin
    #2_000_000;
    bad_count++;
    final_report();
  end

  //----------------------------------------
  // test sequence
  //----------------------------------------
  initial begin
    bad_count = 0;
    n_compared = 0;
    reset_n = 1'b0;
    power_down_pin = 1'b0;
    repeat (2) @(posedge clock);
    #1;
    reset_n = 1'b1;
    settle(3);
    rchk(`ADDR_POWER_MODE, 8'h00);
    rchk(`ADDR_ENHANCEMENT, 8'h00);
    rchk(`ADDR_OUTPUT_MODE, 8'h01);
    rchk(`ADDR_OUTPUT_ADJUST, 8'h00);
    rchk(`ADDR_CLOCK_PHASE, 8'h03);
    chk(twos_complement, 8'hFF);
    chk(channel_active, 8'hFF);
    $display("reset values done");
    for (int m = 0; m < 4; m++) begin
      i_host.wr(`ADDR_POWER_MODE, 8'(m));
      settle(1);
      chk(path_clock_gate, gate_tab[m]);
      chk(path_reset, rst_tab[m]);
      chk(output_enable, oe_tab[m]);
      chk(channel_active, (m == 0) ? 8'hFF : 8'h00);
    end
    rchk(`ADDR_POWER_MODE, 8'h03);
    i_host.wr(`ADDR_POWER_MODE, 8'h20);
    power_down_pin = 1'b1;
    settle(5);
    chk(path_clock_gate, 8'hFF);
    chk(path_reset, 8'h00);
    chk(output_enable, 8'h00);
    i_host.wr(`ADDR_POWER_MODE, 8'h00);
    settle(1);
    chk(path_reset, 8'hFF);
    power_down_pin = 1'b0;
    settle(5);
    chk(output_enable, 8'hFF);
    $display("power modes done");
    i_host.wr(`ADDR_DEVICE_INDEX_A, 8'h00);
    i_host.wr(`ADDR_DEVICE_INDEX_B, 8'h01);
    i_host.wr(`ADDR_ENHANCEMENT, 8'h04);
    i_host.wr(`ADDR_OUTPUT_MODE, 8'h44);
    settle(1);
    chk(chop_enable, 8'h01);
    chk(ieee_standard, 8'h01);
    chk(invert_stream, 8'h01);
    chk(twos_complement, 8'hFE);
    rchk(`ADDR_OUTPUT_MODE, 8'h44);
    i_host.wr(`ADDR_DEVICE_INDEX_A, 8'h02);
    i_host.wr(`ADDR_DEVICE_INDEX_B, 8'h00);
    i_host.wr(`ADDR_ENHANCEMENT, 8'h04);
    settle(1);
    chk(chop_enable, 8'h21);
    rchk(`ADDR_ENHANCEMENT, 8'h04);
    i_host.wr(`ADDR_DEVICE_INDEX_B, 8'h30);
    i_host.wr(`ADDR_OUTPUT_ADJUST, 8'h01);
    settle(1);
    chk({6'h00, fco_double, dco_double}, 8'h03);
    i_host.wr(`ADDR_OUTPUT_ADJUST, 8'h21);
    settle(1);
    chk({6'h00, termination}, 8'h02);
    chk({6'h00, fco_double, dco_double}, 8'h00);
    $display("output controls done");
    i_host.wr(`ADDR_CLOCK_PHASE, 8'h7B);
    settle(1);
    chk({5'h00, input_phase_delay}, 8'h07);
    chk({4'h0, output_phase_code}, 8'h0B);
    i_host.wr(`ADDR_CLOCK_PHASE, 8'h2C);
    settle(1);
    chk({5'h00, input_phase_delay}, 8'h02);
    chk({4'h0, output_phase_code}, 8'h0B);
    rchk(`ADDR_CLOCK_PHASE, 8'h2B);
    $display("phase adjust done");
    i_host.wr(`ADDR_OVERRIDE, 8'h5A);
    i_host.wr(13'h0030, 8'hFF);
    settle(2);
    chk(override_applied, 8'h00);
    rchk(`ADDR_OVERRIDE, 8'h5A);
    rchk(`ADDR_POWER_MODE, 8'h00);
    i_host.wr(`ADDR_COMMIT, 8'h01);
    settle(1);
    chk(override_applied, 8'h5A);
    rchk(`ADDR_COMMIT, 8'h00);
    $display("commit done");
    reset_n = 1'b0;
    settle(2);
    reset_n = 1'b1;
    settle(3);
    chk(override_applied, 8'h00);
    rchk(`ADDR_CLOCK_PHASE, 8'h03);
    $display("power-on reset done");
    final_report();
  end
endmodule // tb
